// ---- hdl/can_ctl_status.sv ----
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/100ps
module can_ctl_status
  import can_ctl_pkg::*;
#(
  parameter int BIT_DIV = 25
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wait_mode,
  input wire logic rx_pin,
  output logic tx_pin,
  input wire logic tx_bit,
  input wire logic rx_busy,
  input wire logic bus_synced,
  input wire logic frame_valid,
  input wire logic frame_acked,
  input wire logic [31:0] frame_ident,
  output logic bus_if_clk_en,
  output logic core_clk_en,
  output logic rx_bit,
  output logic wakeup_irq,
  output logic [15:0] tstamp_out,
  output logic tstamp_write
);
  logic rx_meta_q, rx_sync_q, rx_prev_q;
  logic [7:0] div_q;
  logic bit_tick_q;
  logic rx_frame_q, rx_active_q, sync_q, swait_q, timer_q, wake_q;
  logic init_q, sleep_req_q, sleep_ack_q, loop_q, wie_q, wakeirq_q, rxfull_q;
  logic [1:0] fmode_q;
  logic [31:0] code0_q, code1_q, mask0_q, mask1_q, rxbuf_q, frame_q;
  logic [7:0] hits_q;
  logic [15:0] tstamp_q;
  logic tswr_q, txp_q, rxb_q, busen_q, coreen_q, ack_q, ack_d;
  logic [31:0] rdata_q;
  logic [15:0] count;
  logic [7:0] hits;
  logic accept;

  // pin synchroniser: only the second and third stages feed logic
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_pin;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end
  wire bus_traffic = rx_prev_q & ~rx_sync_q;

  // bit-rate enable pulse from the system clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q <= '0;
      bit_tick_q <= 1'b0;
    end else begin
      bit_tick_q <= (div_q == 8'(BIT_DIV - 1));
      div_q <= (div_q == 8'(BIT_DIV - 1)) ? 8'h00 : div_q + 8'h01;
    end
  end

  // bus slave: one wait cycle, answer on the second edge of a request
  wire req = (avs_read | avs_write) & ~ack_q;
  assign ack_d = req;
  wire wr = avs_write & ack_q;
  wire wr0 = wr & avs_byteenable[0];
  wire wr1 = wr & avs_byteenable[1];
  wire wr_ctl = wr0 & (avs_address == ADDR_CTL0);
  wire wr_mode = wr & (avs_address == ADDR_MODE);
  wire [7:0] ctl_rd = {rx_frame_q, rx_active_q, swait_q, sync_q, timer_q, wake_q, 2'b00};
  wire [31:0] mode_rd = {23'h000000, rxfull_q, wakeirq_q, sleep_ack_q, fmode_q, wie_q, loop_q, sleep_req_q, init_q};
  wire [31:0] rd_mux =
    (avs_address == ADDR_CTL0) ? {24'h000000, ctl_rd} :
    (avs_address == ADDR_TSTAMP) ? {16'h0000, count} :
    (avs_address == ADDR_MODE) ? mode_rd :
    (avs_address == ADDR_CODE0) ? code0_q :
    (avs_address == ADDR_CODE1) ? code1_q :
    (avs_address == ADDR_MASK0) ? mask0_q :
    (avs_address == ADDR_MASK1) ? mask1_q :
    (avs_address == ADDR_HITS) ? {24'h000000, hits_q} :
    (avs_address == ADDR_FRAME) ? frame_q :
    (avs_address == ADDR_RXBUF) ? rxbuf_q : UNMAPPED_READ;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rd_mux;
    end
  end
  assign avs_waitrequest = ~ack_q;
  assign avs_readdata = rdata_q;

  // loopback feeds the transmitter into the receiver
  wire rx_in = loop_q ? tx_bit : rx_sync_q;
  wire sleeping = sleep_req_q & sleep_ack_q;
  // front-end status is masked in loopback since it carries no meaning there
  wire rx_status_ok = ~loop_q;
  wire store = frame_valid & accept & ~sleeping & (fmode_q != FILT_CLOSED);

  // control register and status flags
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_frame_q <= CTL0_RESET[BIT_RX_FRAME];
      rx_active_q <= CTL0_RESET[BIT_RX_ACTIVE];
      swait_q <= CTL0_RESET[BIT_SWAIT];
      sync_q <= CTL0_RESET[BIT_SYNC];
      timer_q <= CTL0_RESET[BIT_TIMER];
      wake_q <= CTL0_RESET[BIT_WAKE];
    end else begin
      // set wins over a clear in the same cycle
      if (frame_valid && rx_status_ok) begin
        rx_frame_q <= 1'b1;
      end else if (wr_ctl && avs_writedata[BIT_RX_FRAME]) begin
        rx_frame_q <= 1'b0;
      end
      rx_active_q <= rx_busy & rx_status_ok;
      sync_q <= bus_synced & ~init_q;
      if (init_q) begin
        timer_q <= 1'b0;
      end else if (wr_ctl) begin
        timer_q <= avs_writedata[BIT_TIMER];
      end
      if (wr_ctl) begin
        swait_q <= avs_writedata[BIT_SWAIT];
        wake_q <= avs_writedata[BIT_WAKE];
      end
    end
  end

  // mode register, sleep handshake and wake interrupt
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      init_q <= 1'b0;
      sleep_req_q <= 1'b0;
      sleep_ack_q <= 1'b0;
      loop_q <= 1'b0;
      wie_q <= 1'b0;
      fmode_q <= FILT_FOUR;
      wakeirq_q <= 1'b0;
    end else begin
      if (wr_mode && avs_byteenable[0]) begin
        init_q <= avs_writedata[BIT_INIT];
        loop_q <= avs_writedata[BIT_LOOP];
        wie_q <= avs_writedata[BIT_WIE];
        fmode_q <= avs_writedata[BIT_FMODE+1:BIT_FMODE];
      end
      // wake-up enable is sampled live; changing it while asleep is the caller's risk
      if (sleeping && wake_q && bus_traffic) begin
        sleep_req_q <= 1'b0;
      end else if (wr_mode && avs_byteenable[0]) begin
        sleep_req_q <= avs_writedata[BIT_SLEEP_REQ];
      end
      // once asleep, incoming traffic must not drop the acknowledge, or no wake-up is ever seen
      sleep_ack_q <= sleep_req_q & (sleep_ack_q | ~rx_busy);
      if (sleeping && wake_q && wie_q && bus_traffic) begin
        wakeirq_q <= 1'b1;
      end else if (wr_mode && avs_byteenable[0] && avs_writedata[BIT_WAKEIRQ]) begin
        wakeirq_q <= 1'b0;
      end
    end
  end

  // filter banks and the foreground receive buffer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      code0_q <= BANK_RESET;
      code1_q <= BANK_RESET;
      mask0_q <= BANK_RESET;
      mask1_q <= BANK_RESET;
      rxbuf_q <= BANK_RESET;
      frame_q <= BANK_RESET;
      hits_q <= 8'h00;
      rxfull_q <= 1'b0;
    end else begin
      if (wr && avs_address == ADDR_CODE0) code0_q <= avs_writedata;
      if (wr && avs_address == ADDR_CODE1) code1_q <= avs_writedata;
      if (wr && avs_address == ADDR_MASK0) mask0_q <= avs_writedata;
      if (wr && avs_address == ADDR_MASK1) mask1_q <= avs_writedata;
      if (store) begin
        rxbuf_q <= frame_ident;
        hits_q <= hits;
        rxfull_q <= 1'b1;
      end else if (wr1 && avs_address == ADDR_MODE && avs_writedata[BIT_RXFULL]) begin
        rxfull_q <= 1'b0;
      end
      // timestamp lands in the top word of the current buffer
      if (frame_acked && timer_q) begin
        frame_q <= {count, frame_q[15:0]};
      end
    end
  end

  // outputs, all registered
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txp_q <= 1'b1;
      rxb_q <= 1'b1;
      busen_q <= 1'b1;
      coreen_q <= 1'b1;
      tstamp_q <= 16'h0000;
      tswr_q <= 1'b0;
    end else begin
      txp_q <= loop_q ? 1'b1 : tx_bit;
      rxb_q <= rx_in;
      busen_q <= ~(swait_q & wait_mode);
      coreen_q <= ~sleeping & ~(swait_q & wait_mode);
      tswr_q <= frame_acked & timer_q;
      tstamp_q <= count;
    end
  end
  assign tx_pin = txp_q;
  assign rx_bit = rxb_q;
  assign bus_if_clk_en = busen_q;
  assign core_clk_en = coreen_q;
  assign tstamp_out = tstamp_q;
  assign tstamp_write = tswr_q;
  assign wakeup_irq = wakeirq_q;

  can_tstamp #(.W(TSTAMP_W)) u_tstamp (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(timer_q),
    .bit_tick(bit_tick_q),
    .count(count)
  );

  can_acc_filter #(.NBANK(2)) u_filter (
    .ident(frame_ident),
    .code({code1_q, code0_q}),
    .mask({mask1_q, mask0_q}),
    .mode(fmode_q),
    .hits(hits),
    .accept(accept)
  );

  rx_frame_set_a: assert property (@(posedge clk_sys) disable iff (reset)
    frame_valid && !loop_q |=> rx_frame_q) else $error("received flag not set");
  rx_frame_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
    rx_frame_q && !(wr_ctl && avs_writedata[BIT_RX_FRAME]) |=> rx_frame_q)
    else $error("received flag lost without clear");
  rx_active_follow_a: assert property (@(posedge clk_sys) disable iff (reset)
    !loop_q |=> rx_active_q == $past(rx_busy)) else $error("active flag wrong");
  loop_mask_a: assert property (@(posedge clk_sys) disable iff (reset)
    loop_q |=> !rx_active_q) else $error("active flag in loopback");
  wait_gate_a: assert property (@(posedge clk_sys) disable iff (reset)
    swait_q && wait_mode |=> !bus_if_clk_en) else $error("bus clock not gated");
  sync_init_a: assert property (@(posedge clk_sys) disable iff (reset)
    init_q |=> !sync_q) else $error("synchronised in init");
  timer_init_a: assert property (@(posedge clk_sys) disable iff (reset)
    init_q |=> !timer_q) else $error("timer enabled in init");
  tstamp_wr_a: assert property (@(posedge clk_sys) disable iff (reset)
    frame_acked && timer_q |=> tstamp_write && frame_q[31:16] == $past(count))
    else $error("timestamp not written");
  closed_full_a: assert property (@(posedge clk_sys) disable iff (reset)
    fmode_q == FILT_CLOSED && !rxfull_q |=> !rxfull_q) else $error("closed filter stored");
  wake_irq_a: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(wakeup_irq) |-> $past(sleeping && wake_q && wie_q)) else $error("bad wake interrupt");
  wake_exit_a: assert property (@(posedge clk_sys) disable iff (reset)
    sleeping && wake_q && bus_traffic |=> !sleep_req_q) else $error("no wake on traffic");
  loop_tx_a: assert property (@(posedge clk_sys) disable iff (reset)
    loop_q |=> tx_pin) else $error("tx not recessive in loopback");
endmodule

// ---- hdl/can_ctl_pkg.sv ----
package can_ctl_pkg;
  // register word addresses on the avalon slave (one step per 32-bit register)
  localparam logic [3:0] ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_TSTAMP = 4'h1;
  localparam logic [3:0] ADDR_MODE = 4'h2;
  localparam logic [3:0] ADDR_CODE0 = 4'h3;
  localparam logic [3:0] ADDR_CODE1 = 4'h4;
  localparam logic [3:0] ADDR_MASK0 = 4'h5;
  localparam logic [3:0] ADDR_MASK1 = 4'h6;
  localparam logic [3:0] ADDR_HITS = 4'h7;
  localparam logic [3:0] ADDR_FRAME = 4'h8;
  localparam logic [3:0] ADDR_RXBUF = 4'h9;
  // control register bit positions
  localparam int BIT_RX_FRAME = 7;
  localparam int BIT_RX_ACTIVE = 6;
  localparam int BIT_SWAIT = 5;
  localparam int BIT_SYNC = 4;
  localparam int BIT_TIMER = 3;
  localparam int BIT_WAKE = 2;
  // mode register bit positions
  localparam int BIT_INIT = 0;
  localparam int BIT_SLEEP_REQ = 1;
  localparam int BIT_LOOP = 2;
  localparam int BIT_WIE = 3;
  localparam int BIT_FMODE = 4;
  localparam int BIT_SLEEP_ACK = 6;
  localparam int BIT_WAKEIRQ = 7;
  localparam int BIT_RXFULL = 8;
  localparam logic [7:0] CTL0_RESET = 8'h00;
  localparam logic [31:0] BANK_RESET = 32'h00000000;
  localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
  // filter modes
  typedef enum logic [1:0] {
    FILT_FOUR = 2'b00,
    FILT_EIGHT = 2'b01,
    FILT_CLOSED = 2'b11
  } filt_mode_e;
  localparam int TSTAMP_W = 16;
endpackage

// ---- hdl/can_acc_filter.sv ----
`timescale 1ns/100ps
module can_acc_filter
  import can_ctl_pkg::*;
#(
  parameter int NBANK = 2
) (
  input wire logic [31:0] ident,
  input wire logic [NBANK*32-1:0] code,
  input wire logic [NBANK*32-1:0] mask,
  input wire logic [1:0] mode,
  output logic [7:0] hits,
  output logic accept
);
  // a set mask bit is a don't-care, a clear one must match the code
  wire [NBANK*32-1:0] miss = (code ^ {NBANK{ident}}) & ~mask;
  logic [3:0] hit4;
  logic [7:0] hit8;
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      // four mode: each half-bank covers the upper 16 identifier bits
      assign hit4[2*b] = ~|miss[b*32+31:b*32+16];
      // the low half holds a second code for the same upper 16 identifier bits
      assign hit4[2*b+1] = ~|((code[b*32+15:b*32] ^ ident[31:16]) & ~mask[b*32+15:b*32]);
      // eight mode: each byte compares the first 8 identifier bits only
      assign hit8[4*b] = ~|miss[b*32+31:b*32+24];
      assign hit8[4*b+1] = ~|((code[b*32+23:b*32+16] ^ ident[31:24]) & ~mask[b*32+23:b*32+16]);
      assign hit8[4*b+2] = ~|((code[b*32+15:b*32+8] ^ ident[31:24]) & ~mask[b*32+15:b*32+8]);
      assign hit8[4*b+3] = ~|((code[b*32+7:b*32] ^ ident[31:24]) & ~mask[b*32+7:b*32]);
    end
  endgenerate
  always_comb begin
    hits = 8'h00;
    unique case (mode)
      FILT_FOUR: hits = {4'h0, hit4};
      FILT_EIGHT: hits = hit8;
      default: hits = 8'h00;
    endcase
  end
  assign accept = |hits;
endmodule

// ---- hdl/can_tstamp.sv ----
`timescale 1ns/100ps
module can_tstamp
  import can_ctl_pkg::*;
#(
  parameter int W = TSTAMP_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enable,
  input wire logic bit_tick,
  output logic [W-1:0] count
);
  logic [W-1:0] count_q;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else if (!enable) begin
      count_q <= '0;
    end else if (bit_tick) begin
      count_q <= count_q + 1'b1;
    end
  end
  assign count = count_q;
  tstamp_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
    !enable |=> count_q == '0) else $error("timestamp not cleared when disabled");
  tstamp_step_a: assert property (@(posedge clk_sys) disable iff (reset)
    enable && $past(enable) && bit_tick |=> count_q == W'($past(count_q) + 1'b1))
    else $error("timestamp did not advance");
endmodule

// ---- testbench/can_far_nodes.sv ----
`timescale 1ns/100ps
// stands in for the other nodes on the bus; the line idles recessive (1) while no frame is being sent
module can_far_nodes (
  input wire logic clk_sys,
  input wire logic send,
  input wire logic [31:0] ident,
  input wire logic hold_busy,
  output logic rx_pin,
  output logic rx_busy,
  output logic frame_valid,
  output logic frame_acked,
  output logic [31:0] frame_ident
);
  logic [4:0] cnt_q = 5'h00;
  initial frame_ident = 32'h0;
  assign rx_busy = hold_busy | (cnt_q != 5'h00);
  // toggling bits inside a frame give the falling edges a sleeping receiver listens for
  assign rx_pin = (cnt_q == 5'h00) | cnt_q[0];
  assign frame_acked = (cnt_q == 5'h03);
  assign frame_valid = (cnt_q == 5'h01);
  always @(posedge clk_sys) begin
    if (send) begin
      cnt_q <= 5'h14;
      frame_ident <= ident;
    end else if (cnt_q != 5'h00) begin
      cnt_q <= cnt_q - 5'h01;
    end else begin
      // identifier is only meaningful within a frame, so it is scrambled outside one
      frame_ident <= ~frame_ident;
    end
  end
endmodule

// ---- testbench/test_can_ctl_status.sv ----
`timescale 1ns/100ps
module test_can_ctl_status;
  import can_ctl_pkg::*;
  typedef struct {
    logic [1:0] fm;
    logic [31:0] c0, c1, m0, m1, id;
    logic [7:0] hits;
  } row_s;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic wait_mode = 1'h0;
  logic tx_bit = 1'h1;
  logic bus_synced = 1'h0;
  logic send = 1'h0;
  logic hold_busy = 1'h0;
  logic [31:0] ident = 32'h0;
  logic [31:0] avs_readdata, frame_ident, q, t1;
  logic avs_waitrequest, rx_pin, tx_pin, rx_busy, frame_valid, frame_acked;
  logic bus_if_clk_en, core_clk_en, rx_bit, wakeup_irq, tstamp_write;
  logic [15:0] tstamp_out;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_ts = 0;
  // mode, code bank 0/1, mask bank 0/1, identifier, hits
  row_s rows [5] = '{
    '{2'h0, 32'h12341234, 32'h0, 32'h0, 32'h0, 32'h12340000, 8'h03},
    '{2'h0, 32'h12351235, 32'h0, 32'h00010001, 32'h0, 32'h12340000, 8'h03},
    '{2'h0, 32'h0, 32'h0, 32'h0, 32'hFFFFFFFF, 32'h12340000, 8'h0C},
    '{2'h1, 32'hABABABAB, 32'h0, 32'h0, 32'h0, 32'hAB000000, 8'h0F},
    '{2'h1, 32'h0, 32'hABABABAB, 32'h0, 32'h0, 32'hAB000000, 8'hF0}
  };

  can_far_nodes far (.clk_sys, .send, .ident, .hold_busy, .rx_pin, .rx_busy, .frame_valid, .frame_acked,
    .frame_ident);
  can_ctl_status #(.BIT_DIV(4)) dut (.clk_sys, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .wait_mode, .rx_pin, .tx_pin, .tx_bit, .rx_busy,
    .bus_synced, .frame_valid, .frame_acked, .frame_ident, .bus_if_clk_en, .core_clk_en, .rx_bit,
    .wakeup_irq, .tstamp_out, .tstamp_write);

  always #20 clk_sys = ~clk_sys;

  task automatic finish_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is about 600 cycles; the ceiling only cuts a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (tstamp_write === 1'h1) n_ts++;
    if (cycles == 20000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low; readdata taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    q = avs_readdata;
    if (n >= 50) num_errors++;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'h1, a, d);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'h0, a, 32'h0);
    chk(q & m, exp);
  endtask

  task automatic frame(input logic [31:0] id);
    @(posedge clk_sys);
    send <= 1'h1;
    ident <= id;
    @(posedge clk_sys);
    send <= 1'h0;
    repeat (30) @(posedge clk_sys);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    chk(avs_waitrequest, 32'h1);
    reset <= 1'h0;
    rd(ADDR_CTL0, 32'hFF, 32'(CTL0_RESET));
    rd(ADDR_CODE0, 32'hFFFFFFFF, BANK_RESET);
    rd(4'hF, 32'hFFFFFFFF, UNMAPPED_READ);
    foreach (rows[i]) begin
      wr(ADDR_CODE0, rows[i].c0);
      wr(ADDR_CODE1, rows[i].c1);
      wr(ADDR_MASK0, rows[i].m0);
      wr(ADDR_MASK1, rows[i].m1);
      wr(ADDR_MODE, {26'h0, rows[i].fm, 4'h0});
      frame(rows[i].id);
      rd(ADDR_HITS, 32'hFF, {24'h0, rows[i].hits});
    end
    rd(ADDR_CTL0, 32'h80, 32'h80);
    wr(ADDR_CTL0, 32'h00);
    rd(ADDR_CTL0, 32'h80, 32'h80);
    wr(ADDR_CTL0, 32'h80);
    rd(ADDR_CTL0, 32'h80, 32'h00);
    wr(ADDR_MODE, 32'h130);
    frame(32'h12340000);
    rd(ADDR_MODE, 32'h100, 32'h0);
    rd(ADDR_RXBUF, 32'hFFFFFFFF, 32'hAB000000);
    rd(ADDR_CTL0, 32'h80, 32'h80);
    hold_busy <= 1'h1;
    bus_synced <= 1'h1;
    repeat (4) @(posedge clk_sys);
    rd(ADDR_CTL0, 32'h50, 32'h50);
    hold_busy <= 1'h0;
    bus_synced <= 1'h0;
    repeat (4) @(posedge clk_sys);
    rd(ADDR_CTL0, 32'h50, 32'h00);
    wr(ADDR_CTL0, 32'h20);
    wait_mode <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk(bus_if_clk_en, 32'h0);
    wait_mode <= 1'h0;
    wr(ADDR_CTL0, 32'h00);
    wait_mode <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk(bus_if_clk_en, 32'h1);
    wait_mode <= 1'h0;
    wr(ADDR_CTL0, 32'h08);
    repeat (40) @(posedge clk_sys);
    bus(1'h0, ADDR_TSTAMP, 32'h0);
    t1 = q;
    repeat (40) @(posedge clk_sys);
    bus(1'h0, ADDR_TSTAMP, 32'h0);
    // about 43 cycles at one tick per 4; slack for where the divider phase sits
    chk(32'((q - t1) >= 32'h8 && (q - t1) <= 32'hC), 32'h1);
    n_ts = 0;
    frame(32'h12340000);
    chk(n_ts, 32'h1);
    wr(ADDR_CTL0, 32'h00);
    rd(ADDR_TSTAMP, 32'hFFFF, 32'h0);
    chk(32'(tstamp_out), 32'h0);
    wr(ADDR_MODE, 32'h01);
    wr(ADDR_CTL0, 32'h08);
    rd(ADDR_CTL0, 32'h08, 32'h0);
    wr(ADDR_MODE, 32'h04);
    tx_bit <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk({tx_pin, rx_bit}, 32'h2);
    tx_bit <= 1'h1;
    repeat (4) @(posedge clk_sys);
    chk({tx_pin, rx_bit}, 32'h3);
    wr(ADDR_CTL0, 32'h04);
    wr(ADDR_MODE, 32'h0A);
    repeat (4) @(posedge clk_sys);
    rd(ADDR_MODE, 32'h40, 32'h40);
    chk(core_clk_en, 32'h0);
    frame(32'h0);
    chk(wakeup_irq, 32'h1);
    wr(ADDR_MODE, 32'h80);
    wr(ADDR_CTL0, 32'h00);
    wr(ADDR_MODE, 32'h0A);
    repeat (4) @(posedge clk_sys);
    frame(32'h0);
    chk(wakeup_irq, 32'h0);
    // mid-run reset: outputs return to idle at once, registers to their reset values
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk({avs_waitrequest, tx_pin, rx_bit, wakeup_irq, core_clk_en}, 32'h1D);
    reset <= 1'h0;
    rd(ADDR_MODE, 32'hFFFF, 32'h0);
    rd(ADDR_CTL0, 32'hFF, 32'(CTL0_RESET));
    finish_test();
  end
endmodule
